// ==== rtl/spi_mm_consts.svh ====
// Offsets, field positions, reset values and codes of the read engine
`ifndef SPI_MM_CONSTS_SVH
`define SPI_MM_CONSTS_SVH
`define REG_CTRL0 4'h0
`define REG_DIV 4'h4
`define REG_TOUT 4'h8
`define REG_STAT 4'hC
`define CTRL_W 11
`define CTRL_RST 11'h000
`define DIV_RST 16'h0000
`define TOUT_RST 8'h40
`define F_EN 0
`define F_LANE_LO 1
`define F_LANE_HI 2
`define F_CONT 3
`define F_PREF 4
`define F_WDOG 5
`define F_INSTR 6
`define F_ISEL_LO 7
`define F_ISEL_HI 8
`define F_DIR_LO 9
`define F_DIR_HI 10
`define DIR_TX_ONLY 2'h1
`define INSTR_0 8'h03
`define INSTR_1 8'h0B
`define INSTR_2 8'h3B
`define INSTR_3 8'h6B
`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3
`define DESEL_CYC 8'h02
`define WORD_BITS 6'h20
`define ADDR_BITS 6'h18
`define CMD_BITS 6'h08
`endif

// ==== rtl/spi_mm_pkg.sv ====
// Types shared by the serial memory read engine
package spi_mm_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_DESEL, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_HOLD
	} eng_state_type;
	typedef struct packed {
		logic sclk;
		logic selectN;
		logic [7:0] txd;
		logic [7:0] oeLanes;
	} link_out_type;
	typedef struct packed {
		eng_state_type eng;
		link_out_type link;
		logic [15:0] divCnt;
		logic [31:0] shOut;
		logic [31:0] shIn;
		logic [5:0] bitsLeft;
		logic [6:0] fetchLeft;
		logic [21:0] fetchAddr;
		logic [21:0] expAddr;
		logic [4:0] wrPtr;
		logic [4:0] rdPtr;
		logic [4:0] count;
		logic [7:0] wdCnt;
		logic [10:0] ctrl;
		logic [15:0] div;
		logic [7:0] tout;
		logic waitReq;
		logic [31:0] rdata;
		logic [1:0] resp;
		logic popPend;
		logic wrOk;
		logic [7:0] rxMeta;
		logic [7:0] rxSync;
	} eng_regs_type;
endpackage

// ==== rtl/fifo_mem.sv ====
// Receive word store with registered read data
`timescale 1ns/1ps
module fifo_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic clk,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic rdEn,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		if (rdEn) begin
			rdData <= mem[rdAddr];
		end
	end
endmodule // fifo_mem

// ==== rtl/spi_mm_read_engine.sv ====
// Contract
// - Lane mode widens transmit, receive and enable groups to 2, 4 or 8 lines
// - Transfer direction comes from the direction field of control register
// - Sideband select high means memory read, low means register access
// - Each memory read is served in the same bus transaction, stretched
// - Serial memory address is taken from the bus address
// - Optional instruction phase from a fixed code set precedes the address
// - Outside continuous mode every memory read sends a fresh address; here a read found in the FIFO sends none
// - Continuous mode keeps memory selected, clock idle, after data arrives
// - Later continuous reads restart the clock, no command, address, dummies
// - Continuous mode deselects on any transaction with the select low; here only while the engine is in ST_HOLD
// - Non-consecutive continuous read deselects then restarts with address
// - Watchdog deselects when no memory read arrives within the idle count
// - Idle count is 8 bits of core clock; writes ignored while enabled
// - Prefetch fetches the next burst; next-address request served from FIFO
// - Prefetch amount is the lesser of last burst length and FIFO depth
// - Serving prefetched data starts the next chunk fetch in parallel
// - Non-contiguous request flushes the FIFO and starts a fresh read
// - Request during prefetch either ends it or extends the beat count; here a matching request only waits, count not extended
// - Serial clock is core clock over an even divisor; zero disables it
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "spi_mm_consts.svh"
module spi_mm_read_engine #(
	parameter int DEPTH = 8,
	parameter int DUMMY_CLKS = 0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [31:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic memMapSel,
	input wire logic [5:0] burstcount,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic [1:0] response,
	input wire logic [7:0] rxd,
	output spi_mm_pkg::link_out_type spiOut
);
	import spi_mm_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam logic [4:0] DEPTH_C = 5'(DEPTH);
	localparam logic [4:0] PTR_MASK = 5'(DEPTH - 1);

	eng_regs_type q;
	eng_regs_type d;
	logic rstMeta;
	logic rstSyncN;
	logic memWrEn;
	logic memRdEn;
	logic [31:0] rdData;
	logic [1:0] mode;
	logic [3:0] step;
	logic [15:0] half;
	logic tick;
	logic req;
	logic [21:0] reqAddr;
	logic [6:0] amt;
	logic [31:0] regVal;
	logic [7:0] laneMask;

	function automatic logic [3:0] laneStep(input logic [1:0] m);
		case (m)
			2'h0: laneStep = 4'h1;
			2'h1: laneStep = 4'h2;
			2'h2: laneStep = 4'h4;
			default: laneStep = 4'h8;
		endcase
	endfunction

	function automatic logic [7:0] topBits(input logic [31:0] s,
		input logic [1:0] m);
		case (m)
			2'h0: topBits = {7'h00, s[31]};
			2'h1: topBits = {6'h00, s[31:30]};
			2'h2: topBits = {4'h0, s[31:28]};
			default: topBits = s[31:24];
		endcase
	endfunction

	function automatic logic [31:0] shiftIn(input logic [31:0] s,
		input logic [7:0] r, input logic [1:0] m);
		case (m)
			2'h0: shiftIn = {s[30:0], r[0]};
			2'h1: shiftIn = {s[29:0], r[1:0]};
			2'h2: shiftIn = {s[27:0], r[3:0]};
			default: shiftIn = {s[23:0], r};
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	function automatic logic [7:0] instrCode(input logic [1:0] sel);
		case (sel)
			2'h0: instrCode = `INSTR_0;
			2'h1: instrCode = `INSTR_1;
			2'h2: instrCode = `INSTR_2;
			default: instrCode = `INSTR_3;
		endcase
	endfunction

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstMeta <= 1'b0;
			rstSyncN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSyncN <= rstMeta;
		end
	end

	fifo_mem #(.WIDTH(32), .DEPTH(DEPTH), .AW(AW)) rxStore (
		.clk(clk),
		.wrEn(memWrEn),
		.wrAddr(q.wrPtr[AW-1:0]),
		.wrData(q.shIn),
		.rdEn(memRdEn),
		.rdAddr(q.rdPtr[AW-1:0]),
		.rdData(rdData)
	);

	assign mode = q.ctrl[`F_LANE_HI:`F_LANE_LO];
	assign step = laneStep(mode);
	assign laneMask = 8'((9'h002 << (step - 4'h1)) - 9'h001);
	assign half = {1'b0, q.div[15:1]};
	assign tick = (half != 16'h0000) && (q.divCnt == half - 16'h0001);
	assign reqAddr = address[23:2];
	assign amt = (burstcount == 6'h00) ? 7'h01 :
		((7'(burstcount) > 7'(DEPTH_C)) ? 7'(DEPTH_C) : 7'(burstcount));

	always_comb begin
		case (address[3:0])
			`REG_CTRL0: regVal = {21'h000000, q.ctrl};
			`REG_DIV: regVal = {16'h0000, q.div};
			`REG_TOUT: regVal = {24'h000000, q.tout};
			`REG_STAT: regVal = {24'h000000, q.count, q.fetchLeft != 7'h00,
				q.eng != ST_IDLE, !q.link.selectN};
			default: regVal = 32'h00000000;
		endcase
	end

	always_comb begin
		d = q;
		memWrEn = 1'b0;
		memRdEn = 1'b0;
		req = (read || write) && q.waitReq && !q.popPend;
		d.rxMeta = rxd;
		d.rxSync = q.rxMeta;

		// Answer cycle: writes land at the edge that ends it
		if (!q.waitReq) begin
			d.waitReq = 1'b1;
			d.resp = `RESP_OK;
			if (q.wrOk && write) begin
				case (address[3:0])
					`REG_CTRL0: d.ctrl = `CTRL_W'(merge(
						{21'h000000, q.ctrl}, writedata, byteenable));
					`REG_DIV: d.div = 16'(merge({16'h0000, q.div},
						writedata, byteenable));
					`REG_TOUT: if (!q.ctrl[`F_EN]) begin
						d.tout = 8'(merge({24'h000000, q.tout},
							writedata, byteenable));
					end
					default: d.div = q.div;
				endcase
			end
		end
		// popped word returned in the stretched transaction
		if (q.popPend) begin
			d.popPend = 1'b0;
			d.rdata = rdData;
			d.resp = `RESP_OK;
			d.waitReq = 1'b0;
		end

		// Serial engine
		if (q.eng == ST_CMD || q.eng == ST_ADDR || q.eng == ST_DUMMY ||
			q.eng == ST_DATA) begin
			d.divCnt = tick ? 16'h0000 : q.divCnt + 16'h0001;
		end else begin
			d.divCnt = 16'h0000;
		end
		if (tick && q.eng != ST_IDLE && q.eng != ST_DESEL &&
			q.eng != ST_HOLD) begin
			if (!q.link.sclk) begin
				d.link.sclk = 1'b1;
				if (q.eng == ST_DATA) begin
					d.shIn = shiftIn(q.shIn, q.rxSync, mode);
				end
			end else begin
				d.link.sclk = 1'b0;
				d.bitsLeft = (q.eng == ST_DUMMY) ? q.bitsLeft - 6'h01 :
					q.bitsLeft - 6'(step);
				d.shOut = q.shOut << step;
				d.link.txd = topBits(d.shOut, mode) & laneMask;
				if (d.bitsLeft == 6'h00) begin
					case (q.eng)
						ST_CMD: begin
							d.eng = ST_ADDR;
							d.shOut = {q.fetchAddr, 2'h0, 8'h00};
							d.bitsLeft = `ADDR_BITS;
							d.link.txd = topBits(d.shOut, mode) & laneMask;
						end
						ST_ADDR, ST_DUMMY: begin
							d.link.oeLanes = 8'h00;
							if (q.eng == ST_ADDR && DUMMY_CLKS != 0) begin
								d.eng = ST_DUMMY;
								d.bitsLeft = 6'(DUMMY_CLKS);
							end else begin
								d.eng = ST_DATA;
								d.bitsLeft = `WORD_BITS;
							end
						end
						default: begin
							memWrEn = 1'b1;
							d.wrPtr = (q.wrPtr + 5'h01) & PTR_MASK;
							d.count = q.count + 5'h01;
							d.fetchAddr = q.fetchAddr + 22'h000001;
							d.fetchLeft = q.fetchLeft - 7'h01;
							d.bitsLeft = `WORD_BITS;
							if (d.fetchLeft == 7'h00 || d.count >= DEPTH_C) begin
								d.eng = ST_HOLD;
								d.wdCnt = q.tout;
							end
						end
					endcase
				end
			end
		end

		case (q.eng)
			ST_DESEL: begin
				d.link.selectN = 1'b1;
				d.wdCnt = q.wdCnt - 8'h01;
				if (q.wdCnt == 8'h00) begin
					d.link.selectN = 1'b0;
					d.link.sclk = 1'b0;
					d.link.oeLanes = laneMask;
					if (q.ctrl[`F_INSTR]) begin
						d.eng = ST_CMD;
						d.shOut = {instrCode(q.ctrl[`F_ISEL_HI:`F_ISEL_LO]),
							24'h000000};
						d.bitsLeft = `CMD_BITS;
					end else begin
						d.eng = ST_ADDR;
						d.shOut = {q.fetchAddr, 2'h0, 8'h00};
						d.bitsLeft = `ADDR_BITS;
					end
					d.link.txd = topBits(d.shOut, mode) & laneMask;
				end
			end
			ST_HOLD: begin
				d.link.sclk = 1'b0;
				d.link.oeLanes = 8'h00;
				if (q.fetchLeft != 7'h00 && q.count < DEPTH_C) begin
					d.eng = ST_DATA;
					d.bitsLeft = `WORD_BITS;
				end else if (!q.ctrl[`F_CONT]) begin
					d.eng = ST_IDLE;
					d.fetchLeft = 7'h00;
					d.link.selectN = 1'b1;
				end else if (q.fetchLeft == 7'h00 && q.ctrl[`F_WDOG]) begin
					d.wdCnt = q.wdCnt - 8'h01;
					if (q.wdCnt == 8'h00) begin
						d.eng = ST_IDLE;
						d.link.selectN = 1'b1;
						d.count = 5'h00;
						d.rdPtr = d.wrPtr;
					end
				end
			end
			default: d.wdCnt = d.wdCnt;
		endcase

		// Request decision, after the engine so a flush wins over a push
		if (req) begin
			if (!memMapSel) begin
				d.waitReq = 1'b0;
				d.rdata = regVal;
				d.wrOk = address[3:0] <= `REG_STAT && address[1:0] == 2'h0;
				d.resp = d.wrOk ? `RESP_OK : `RESP_DECERR;
				if (q.ctrl[`F_CONT] && q.eng == ST_HOLD) begin
					d.eng = ST_IDLE;
					d.link.selectN = 1'b1;
					d.fetchLeft = 7'h00;
					d.count = 5'h00;
					d.rdPtr = d.wrPtr;
				end
			end else if (write || !q.ctrl[`F_EN] ||
				q.ctrl[`F_DIR_HI:`F_DIR_LO] == `DIR_TX_ONLY) begin
				d.waitReq = 1'b0;
				d.wrOk = 1'b0;
				d.rdata = 32'h00000000;
				d.resp = `RESP_SLVERR;
			end else begin
				d.wdCnt = (q.eng == ST_HOLD) ? q.tout : d.wdCnt;
				if (q.count != 5'h00 && reqAddr == q.expAddr) begin
					memRdEn = 1'b1;
					d.popPend = 1'b1;
					d.rdPtr = (q.rdPtr + 5'h01) & PTR_MASK;
					d.count = d.count - 5'h01;
					d.expAddr = q.expAddr + 22'h000001;
					if (q.ctrl[`F_PREF] && q.fetchLeft == 7'h00) begin
						d.fetchLeft = amt;
						// Hold may drop to idle in this same cycle
						if (d.eng == ST_IDLE) begin
							d.eng = ST_DESEL;
							d.wdCnt = `DESEL_CYC;
						end
					end
				end else if (q.count == 5'h00 && reqAddr == q.fetchAddr &&
					q.eng != ST_IDLE) begin
					if (q.fetchLeft == 7'h00) begin
						d.fetchLeft = amt;
					end
				end else begin
					d.eng = ST_DESEL;
					d.wdCnt = `DESEL_CYC;
					d.link.selectN = 1'b1;
					d.link.sclk = 1'b0;
					d.link.oeLanes = 8'h00;
					d.count = 5'h00;
					d.rdPtr = d.wrPtr;
					d.fetchAddr = reqAddr;
					d.expAddr = reqAddr;
					d.fetchLeft = q.ctrl[`F_PREF] ? 7'(amt << 1) : amt;
				end
			end
		end

		if (!q.ctrl[`F_EN]) begin
			d.eng = ST_IDLE;
			d.link.selectN = 1'b1;
			d.link.sclk = 1'b0;
			d.link.oeLanes = 8'h00;
			d.fetchLeft = 7'h00;
			d.count = 5'h00;
			d.rdPtr = d.wrPtr;
		end
	end

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			q <= '0;
			q.eng <= ST_IDLE;
			q.link.selectN <= 1'b1;
			q.ctrl <= `CTRL_RST;
			q.div <= `DIV_RST;
			q.tout <= `TOUT_RST;
			q.waitReq <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign readdata = q.rdata;
	assign waitrequest = q.waitReq;
	assign response = q.resp;
	assign spiOut = q.link;
endmodule // spi_mm_read_engine

// ==== tb/spi_mm_checker.sv ====
// Port checks of the read engine
`timescale 1ns/1ps
module spi_mm_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [31:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic memMapSel,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic [1:0] response,
	input spi_mm_pkg::link_out_type spiOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_regRd;
		read && !memMapSel && waitrequest;
	endsequence
	sequence s_memWr;
		write && memMapSel && waitrequest;
	endsequence
	property p_pulse;
		!waitrequest |=> waitrequest;
	endproperty
	property p_regAns;
		s_regRd |-> ##[1:3] !waitrequest;
	endproperty
	property p_decErr;
		s_regRd ##0 address[3:0] == 4'h2 |->
			##[1:3] (!waitrequest && response == 2'h3 && readdata == 32'h0);
	endproperty
	property p_wrErr;
		s_memWr |-> ##[1:3] (!waitrequest && response == 2'h2);
	endproperty
	property p_wrQuiet;
		s_memWr ##0 spiOut.selectN |=> spiOut.selectN;
	endproperty
	property p_idleClk;
		spiOut.selectN |-> !spiOut.sclk;
	endproperty
	property p_gap;
		$rose(spiOut.selectN) |-> spiOut.selectN [*3];
	endproperty
	property p_oeOff;
		spiOut.selectN |-> spiOut.oeLanes == 8'h00;
	endproperty
	property p_oeOn;
		$fell(spiOut.selectN) |-> spiOut.oeLanes != 8'h00;
	endproperty
	a_pulse: assert property (p_pulse) else $error("wait low too long");
	a_regAns: assert property (p_regAns) else $error("no reg answer");
	a_decErr: assert property (p_decErr) else $error("bad decode");
	a_wrErr: assert property (p_wrErr) else $error("no write error");
	a_wrQuiet: assert property (p_wrQuiet) else $error("write selected");
	a_idleClk: assert property (p_idleClk) else $error("clock moved");
	a_gap: assert property (p_gap) else $error("short deselect");
	a_oeOff: assert property (p_oeOff) else $error("lanes driven");
	a_oeOn: assert property (p_oeOn) else $error("lanes idle");
endmodule // spi_mm_checker
bind spi_mm_read_engine spi_mm_checker chk (.clk, .rstn, .address, .read,
	.write, .memMapSel, .readdata, .waitrequest, .response, .spiOut);

// ==== tb/flash_model.sv ====
// Serial flash answering reads
`timescale 1ns/1ps
module flash_model (
	input spi_mm_pkg::link_out_type spiOut,
	input wire logic [1:0] laneLog,
	input wire logic cmdOn,
	output logic [7:0] rxd,
	output logic [31:0] hdr,
	output logic [7:0] heads
);
	int cnt;
	int n;
	int h;
	logic [31:0] w;
	function automatic logic [31:0] f(input logic [21:0] a);
		return {a[15:0] ^ 16'hA5C3, a[15:0]};
	endfunction
	initial begin
		cnt = 0;
		rxd = 8'h00;
		hdr = 32'h0;
		heads = 8'h00;
	end
	assign n = 1 << laneLog;
	assign h = cmdOn ? 32 : 24;
	always @(negedge spiOut.selectN) begin
		cnt = 0;
		hdr = 32'h0;
	end
	always @(posedge spiOut.sclk) if (!spiOut.selectN) begin
		if (cnt < h)
			hdr = (hdr << n) | (spiOut.txd & 8'((1 << n) - 1));
		cnt = cnt + n;
		if (cnt == h)
			heads = heads + 8'h01;
	end
	always @(negedge spiOut.sclk) if (!spiOut.selectN && cnt >= h) begin
		w = f(hdr[23:2] + 22'((cnt - h) / 32));
		rxd <= 8'(w >> (32 - (cnt - h) % 32 - n)) & 8'((1 << n) - 1);
	end
	// No stale value once released
	always @(posedge spiOut.selectN) rxd <= ~rxd;
endmodule // flash_model

// ==== tb/spi_mm_read_engine_tb.sv ====
// Self-checking bench of the read engine
`timescale 1ns/1ps
module spi_mm_read_engine_tb;
	import spi_mm_pkg::*;
	logic clk = 0;
	logic rstn = 0;
	logic [31:0] address = 0;
	logic read = 0;
	logic write = 0;
	logic [31:0] writedata = 0;
	logic memMapSel = 0;
	logic [5:0] burstcount = 1;
	logic [31:0] readdata;
	logic waitrequest;
	logic [1:0] response;
	logic [7:0] rxd;
	link_out_type spiOut;
	logic [1:0] laneLog = 0;
	logic cmdOn = 0;
	logic [31:0] hdr;
	logic [7:0] heads;
	logic [7:0] h0;
	logic [31:0] rd;
	logic [31:0] a;
	logic [1:0] rs;
	logic [7:0] codes [4] = '{8'h03, 8'h0B, 8'h3B, 8'h6B};
	int errors = 0;
	int tests_run = 0;
	always #5 clk = ~clk;
	spi_mm_read_engine DUT (.clk, .rstn, .address, .read, .write, .writedata,
		.byteenable(4'hF), .memMapSel, .burstcount, .readdata, .waitrequest,
		.response, .rxd, .spiOut);
	flash_model FM (.spiOut, .laneLog, .cmdOn, .rxd, .hdr, .heads);
	function automatic logic [31:0] f(input logic [31:0] x);
		return {x[17:2] ^ 16'hA5C3, x[17:2]};
	endfunction
	task automatic bus(input logic wr, input logic sel, input logic [31:0] ad,
		input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk);
		read <= !wr;
		write <= wr;
		memMapSel <= sel;
		address <= ad;
		writedata <= d;
		do @(posedge clk); while (waitrequest !== 1'b0 && ++t < 3000);
		rd = readdata;
		rs = response;
		read <= 1'b0;
		write <= 1'b0;
		if (t >= 3000)
			errors++;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#400000;
		errors++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(32'hEF838C1B));
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		bus(0, 0, 32'h4, 0); chk("div", 32'h0, rd);
		bus(0, 0, 32'h8, 0); chk("tout", 32'h40, rd);
		bus(0, 0, 32'h2, 0); chk("decode", 32'h3, 32'(rs));
		bus(0, 1, 32'h0, 0); chk("off", 32'h2, 32'(rs));
		bus(1, 0, 32'h4, 32'h8);
		bus(1, 0, 32'h8, 32'h10);
		bus(1, 0, 32'h0, 32'h201);
		bus(0, 1, 32'h0, 0); chk("dir", 32'h2, 32'(rs));
		bus(1, 0, 32'h0, 32'h1);
		bus(1, 0, 32'h8, 32'h99);
		bus(0, 0, 32'h8, 0); chk("locked", 32'h10, rd);
		bus(1, 1, 32'h0, 32'h5); chk("memwr", 32'h2, 32'(rs));
		cmdOn = 1;
		for (int i = 0; i < 4; i++) begin
			laneLog = 2'(i);
			bus(1, 0, 32'h0, 32'h41 | (i << 1) | (i << 7));
			a = $urandom & 32'hFFFFFC;
			h0 = heads;
			bus(0, 1, a, 0); chk("lane", f(a), rd);
			chk("addr", a[23:0], hdr[23:0]);
			chk("cmd", 32'(codes[i]), 32'(hdr[31:24]));
			chk("fresh", 32'(h0 + 8'h01), 32'(heads));
		end
		cmdOn = 0;
		laneLog = 0;
		bus(1, 0, 32'h0, 32'h9);
		bus(0, 1, a, 0); chk("cont", f(a), rd);
		h0 = heads;
		bus(0, 1, a + 4, 0); chk("next", f(a + 4), rd);
		chk("nohead", 32'(h0), 32'(heads));
		chk("held", 32'h0, 32'(spiOut.selectN));
		bus(0, 1, a + 32'h100, 0); chk("jump", f(a + 32'h100), rd);
		chk("rehead", 32'(h0 + 8'h01), 32'(heads));
		bus(0, 0, 32'h0, 0);
		repeat (3) @(posedge clk);
		chk("regdesel", 32'h1, 32'(spiOut.selectN));
		bus(1, 0, 32'h0, 32'h29);
		bus(0, 1, a, 0); chk("wdrd", f(a), rd);
		repeat (6) @(posedge clk);
		chk("wdhold", 32'h0, 32'(spiOut.selectN));
		repeat (16) @(posedge clk);
		chk("wdrop", 32'h1, 32'(spiOut.selectN));
		bus(1, 0, 32'h0, 32'h11);
		for (int k = 0; k < 6; k++) begin
			burstcount <= 6'($urandom_range(1, 4));
			if (k == 4)
				a = a + 32'h40;
			bus(0, 1, a, 0); chk("pref", f(a), rd);
			a = a + 4;
		end
		tally_and_finish;
	end
endmodule // spi_mm_read_engine_tb
